// ---- src/acs_pkg.sv ----
// package: constants, register map and carriers for the serial slave
// How it works
// - ctrl bit 3 starts continuous test, guarded
// - ctrl bit 2 runs memory test, blocks writes
// - memory test refused under power-down or sleep
// - ctrl bit 1 starts start-up test, self-clears
// - both self-tests may run together
// - output floats between frames or always
// - keys 0C, 05, 0F in order reset
// - fixed revision code at address 0
// - identity loaded at reset and soft reset, writes touch register only
// - identity top bit marks multi-axis part
// - select low frames each transaction
// - msb first, drive falling, sample rising
// - 16 bits: address, read/write, parity
// - second byte is write data only
// - header: error, power-on, test, saturation, 0, 1, parity
// - data parity is odd over data byte
// - write frame returns old register contents
// - commit on select rise, invalid frame dropped
// - reserved addresses read as zero
// - short or misaligned frame sets frame error, except during memory test
// - power-on flag set by hard reset or undervolt, cleared by soft reset, writes can only clear it
package acs_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int MEMTEST_US = 85;
   localparam int MEMTEST_CYC = MEMTEST_US * (CLK_HZ / 1_000_000);
   localparam int STARTUP_TEST_US = 100;
   localparam int STARTUP_TEST_CYC = STARTUP_TEST_US * (CLK_HZ / 1_000_000);
   localparam logic [5:0] ADDR_REVISION = 6'h00;
   localparam logic [5:0] ADDR_CTRL = 6'h01;
   localparam logic [5:0] ADDR_KEYED_RESET = 6'h03;
   localparam logic [5:0] ADDR_IDENTITY = 6'h27;
   localparam logic [7:0] KEY_FIRST = 8'h0C;
   localparam logic [7:0] KEY_SECOND = 8'h05;
   localparam logic [7:0] KEY_THIRD = 8'h0F;
   localparam logic [7:0] RESET_VAL = 8'h00;
   localparam int CTRL_FLOAT = 0;
   localparam int CTRL_STARTUP_ST = 1;
   localparam int CTRL_MEM_ST = 2;
   localparam int CTRL_CONT_ST = 3;
   localparam int CTRL_SLEEP = 4;
   localparam int CTRL_PDOWN = 5;
   localparam int CTRL_POWER_ON = 6;
   localparam logic [7:0] CTRL_WMASK = 8'h7f;
   localparam int FRAME_BITS = 16;
   localparam int ADDR_BITS = 6;
   localparam logic [5:0] CNT_MAX = 6'h3f;
   localparam logic [5:0] CNT_FRAME = 6'h10;
   localparam logic [5:0] CNT_ADDR = 6'h06;
   // header positions, counted in falling edges after the first bit
   localparam logic [5:0] HDR_FRAME_ERROR_FLAG = 6'h01;
   localparam logic [5:0] HDR_POWER_ON_FLAG = 6'h02;
   localparam logic [5:0] HDR_ST = 6'h03;
   localparam logic [5:0] HDR_SAT = 6'h04;
   localparam logic [5:0] HDR_ZERO = 6'h05;
   localparam logic [5:0] HDR_ONE = 6'h06;
   localparam logic [5:0] HDR_DATA_PARITY = 6'h07;
   localparam logic [5:0] HDR_DATA = 6'h08;
   // arbitrary neutral codes
   localparam logic [7:0] REVISION_CODE = 8'h5A;
   localparam logic MULTI_AXIS = 1'b1;

   typedef struct packed {
      logic [5:0] addr;
      logic rw;
      logic parity;
      logic [7:0] data;
   } acs_frame_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] keyed;
      logic [7:0] ident;
      logic frame_err;
      logic saturation_flag;
      logic st;
   } acs_snap_t;

   typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_GOT2} acs_key_t;
endpackage

// ---- src/acs_spi_slave.sv ----
// module: serial register slave with control, keyed reset and identity
`timescale 1ns/10ps
`default_nettype none
module acs_spi_slave
   import acs_pkg::*;
(
   // system
   input wire logic clk_in,
   input wire logic rst_in,
   // serial link
   input wire logic sck_in,
   input wire logic select_low_n_in,
   input wire logic mosi_in,
   output logic miso_out,
   output logic miso_oe_out,
   // sensor side
   input wire logic [7:0] nvm_id_in,
   input wire logic undervolt_in,
   input wire logic st_status_in,
   input wire logic sat_status_in,
   // control outputs
   output logic power_down_out,
   output logic sleep_out,
   output logic cont_selftest_out,
   output logic mem_test_active_out,
   output logic startup_selftest_out,
   output logic soft_reset_out
);
   // link domain state
   logic started_q;
   logic [5:0] cnt_q;
   logic [15:0] shift_q;
   logic [5:0] addr_q;
   logic miso_q;
   logic oe_q;
   // clock domain state
   logic sel_m_q, sel_s_q, sel_prev_q;
   acs_snap_t snap_q;
   logic [7:0] ctrl_q, keyed_q, ident_q;
   logic frame_error_flag_q;
   acs_key_t key_q;
   logic [10:0] mem_cnt_q;
   logic [10:0] sts_cnt_q;
   logic soft_q;
   logic [7:0] rd_data;
   acs_frame_t frm;
   logic frame_end, frame_ok, par_ok, accept;
   logic [7:0] ctrl_new;
   logic blocked;

   // link side: counting and sampling on rising sck
   always_ff @(posedge sck_in or posedge select_low_n_in) begin
      if (select_low_n_in) begin
         started_q <= 1'b0;
      end else begin
         started_q <= 1'b1;
      end
   end

   always_ff @(posedge sck_in) begin
      if (!started_q) begin
         cnt_q <= 6'h01;
      end else if (cnt_q != CNT_MAX) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   always_ff @(posedge sck_in) begin
      if (!started_q) begin
         shift_q <= {15'h0000, mosi_in};
      end else if (cnt_q < CNT_FRAME) begin
         shift_q <= {shift_q[14:0], mosi_in};
      end
   end

   always_ff @(posedge sck_in) begin
      if (started_q && cnt_q == CNT_ADDR - 6'h01) begin
         addr_q <= {shift_q[4:0], mosi_in};
      end
   end

   // read mux over the frozen snapshot
   always_comb begin
      case (addr_q)
         ADDR_REVISION: rd_data = REVISION_CODE;
         ADDR_CTRL: rd_data = snap_q.ctrl;
         ADDR_KEYED_RESET: rd_data = snap_q.keyed;
         ADDR_IDENTITY: rd_data = snap_q.ident;
         default: rd_data = 8'h00;
      endcase
   end

   // link side: drive on falling sck
   always_ff @(negedge sck_in or posedge select_low_n_in) begin
      if (select_low_n_in) begin
         miso_q <= 1'b0;
      end else begin
         case (cnt_q)
            HDR_FRAME_ERROR_FLAG: miso_q <= snap_q.frame_err;
            HDR_POWER_ON_FLAG: miso_q <= snap_q.ctrl[CTRL_POWER_ON];
            HDR_ST: miso_q <= snap_q.st;
            HDR_SAT: miso_q <= snap_q.saturation_flag;
            HDR_ZERO: miso_q <= 1'b0;
            HDR_ONE: miso_q <= 1'b1;
            HDR_DATA_PARITY: miso_q <= ~^rd_data;
            default: begin
               if (cnt_q >= HDR_DATA && cnt_q < CNT_FRAME) begin
                  miso_q <= rd_data[3'(CNT_FRAME - cnt_q - 6'h01)];
               end else begin
                  miso_q <= 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(negedge sck_in or posedge select_low_n_in) begin
      if (select_low_n_in) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= ~snap_q.ctrl[CTRL_FLOAT];
      end
   end

   assign miso_out = miso_q;
   assign miso_oe_out = oe_q;

   // select crossing into the clock domain
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sel_m_q <= 1'b1;
         sel_s_q <= 1'b1;
         sel_prev_q <= 1'b1;
      end else begin
         sel_m_q <= select_low_n_in;
         sel_s_q <= sel_m_q;
         sel_prev_q <= sel_s_q;
      end
   end

   // frame end: link registers are still while select is high
   assign frame_end = sel_s_q && !sel_prev_q;
   assign frm = acs_frame_t'(shift_q);
   assign frame_ok = started_q == 1'b0 && cnt_q >= CNT_FRAME
      && cnt_q[2:0] == 3'h0;
   assign par_ok = ^{frm.addr, frm.rw, frm.parity};
   assign blocked = ctrl_q[CTRL_MEM_ST];
   assign accept = frame_end && frame_ok && par_ok && !blocked && frm.rw;

   // snapshot is only refreshed between frames
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         snap_q <= '0;
      end else if (sel_s_q) begin
         snap_q.ctrl <= ctrl_q;
         snap_q.keyed <= keyed_q;
         snap_q.ident <= ident_q;
         snap_q.frame_err <= frame_error_flag_q;
         snap_q.st <= st_status_in;
         snap_q.saturation_flag <= sat_status_in;
      end
   end

   // frame error flag, reported in the next frame
   always_ff @(posedge clk_in) begin
      if (rst_in || soft_q) begin
         frame_error_flag_q <= 1'b0;
      end else if (frame_end && !blocked) begin
         frame_error_flag_q <= ~frame_ok;
      end
   end

   // control write with guarded start bits
   always_comb begin
      ctrl_new = (ctrl_q & ~CTRL_WMASK) | (frm.data & CTRL_WMASK);
      ctrl_new[CTRL_POWER_ON] = ctrl_q[CTRL_POWER_ON] & frm.data[CTRL_POWER_ON];
      ctrl_new[CTRL_MEM_ST] = frm.data[CTRL_MEM_ST] && !ctrl_q[CTRL_PDOWN]
         && !ctrl_q[CTRL_SLEEP] && !frm.data[CTRL_PDOWN]
         && !frm.data[CTRL_SLEEP];
      ctrl_new[CTRL_CONT_ST] = frm.data[CTRL_CONT_ST] && !ctrl_q[CTRL_PDOWN]
         && !ctrl_q[CTRL_SLEEP] && !frm.data[CTRL_PDOWN]
         && !frm.data[CTRL_SLEEP] && !ctrl_q[CTRL_MEM_ST]
         && !ctrl_new[CTRL_MEM_ST];
      ctrl_new[CTRL_STARTUP_ST] = frm.data[CTRL_STARTUP_ST] && !ctrl_q[CTRL_PDOWN]
         && !ctrl_q[CTRL_SLEEP] && !frm.data[CTRL_PDOWN]
         && !frm.data[CTRL_SLEEP] && !ctrl_q[CTRL_MEM_ST]
         && !ctrl_new[CTRL_MEM_ST];
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctrl_q <= RESET_VAL;
         ctrl_q[CTRL_POWER_ON] <= 1'b1;
      end else if (soft_q) begin
         ctrl_q <= RESET_VAL;
      end else begin
         if (accept && frm.addr == ADDR_CTRL) begin
            ctrl_q <= ctrl_new;
         end
         if (mem_cnt_q == 11'(1)) begin
            ctrl_q[CTRL_MEM_ST] <= 1'b0;
         end
         // a restart in the finishing cycle wins over the self-clear
         if (sts_cnt_q == 11'(1)
               && !(accept && frm.addr == ADDR_CTRL && ctrl_new[CTRL_STARTUP_ST])) begin
            ctrl_q[CTRL_STARTUP_ST] <= 1'b0;
         end
         if (undervolt_in) begin
            ctrl_q[CTRL_POWER_ON] <= 1'b1;
         end
      end
   end

   // memory test timer
   always_ff @(posedge clk_in) begin
      if (rst_in || soft_q) begin
         mem_cnt_q <= '0;
      end else if (accept && frm.addr == ADDR_CTRL && ctrl_new[CTRL_MEM_ST]) begin
         mem_cnt_q <= 11'(MEMTEST_CYC);
      end else if (mem_cnt_q != '0) begin
         mem_cnt_q <= mem_cnt_q - 11'(1);
      end
   end

   // start-up test timer, independent of the continuous test
   always_ff @(posedge clk_in) begin
      if (rst_in || soft_q) begin
         sts_cnt_q <= '0;
      end else if (accept && frm.addr == ADDR_CTRL && ctrl_new[CTRL_STARTUP_ST]) begin
         sts_cnt_q <= 11'(STARTUP_TEST_CYC);
      end else if (sts_cnt_q != '0) begin
         sts_cnt_q <= sts_cnt_q - 11'(1);
      end
   end

   // keyed reset sequence
   always_ff @(posedge clk_in) begin
      if (rst_in || soft_q) begin
         key_q <= KEY_IDLE;
         keyed_q <= RESET_VAL;
         soft_q <= 1'b0;
      end else begin
         soft_q <= 1'b0;
         if (accept && frm.addr == ADDR_KEYED_RESET) begin
            keyed_q <= frm.data;
            case (key_q)
               KEY_IDLE: key_q <= (frm.data == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
               KEY_GOT1: key_q <= (frm.data == KEY_SECOND) ? KEY_GOT2 : KEY_IDLE;
               KEY_GOT2: begin
                  key_q <= KEY_IDLE;
                  soft_q <= (frm.data == KEY_THIRD);
               end
               default: key_q <= KEY_IDLE;
            endcase
         end else if (frame_end) begin
            key_q <= KEY_IDLE;
         end
      end
   end

   // identity: loaded from storage, writes stay local
   always_ff @(posedge clk_in) begin
      if (rst_in || soft_q) begin
         ident_q <= {MULTI_AXIS, nvm_id_in[6:0]};
      end else if (accept && frm.addr == ADDR_IDENTITY) begin
         ident_q <= frm.data;
      end
   end

   assign power_down_out = ctrl_q[CTRL_PDOWN];
   assign sleep_out = ctrl_q[CTRL_SLEEP];
   assign cont_selftest_out = ctrl_q[CTRL_CONT_ST];
   assign mem_test_active_out = ctrl_q[CTRL_MEM_ST];
   assign startup_selftest_out = ctrl_q[CTRL_STARTUP_ST];
   assign soft_reset_out = soft_q;
endmodule
`default_nettype wire

// ---- dv/acs_spi_slave_sva.sv ----
// assertions on the serial slave ports
`timescale 1ns/10ps
`default_nettype none
module acs_spi_slave_sva
   import acs_pkg::*;
(
   // system
   input wire logic clk_in,
   input wire logic rst_in,
   // serial link
   input wire logic select_low_n_in,
   input wire logic miso_out,
   input wire logic miso_oe_out,
   // control outputs
   input wire logic power_down_out,
   input wire logic sleep_out,
   input wire logic cont_selftest_out,
   input wire logic mem_test_active_out,
   input wire logic startup_selftest_out,
   input wire logic soft_reset_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic [11:0] mem_cyc_q;
   always_ff @(posedge clk_in) begin
      mem_cyc_q <= (rst_in || !mem_test_active_out) ? 12'h000 : mem_cyc_q + 12'h001;
   end
   a_idle_float: assert property (select_low_n_in [*6] |-> !miso_oe_out && !miso_out)
      else $error("output driven between frames");
   a_reset_pulse: assert property (soft_reset_out |-> select_low_n_in ##1 !soft_reset_out)
      else $error("soft reset pulse wrong");
   a_cont_guard: assert property ($rose(cont_selftest_out) |->
      !(power_down_out || sleep_out || mem_test_active_out))
      else $error("continuous test started while barred");
   a_mem_guard: assert property ($rose(mem_test_active_out) |->
      !(power_down_out || sleep_out))
      else $error("memory test started while barred");
   a_startup_guard: assert property ($rose(startup_selftest_out) |->
      !(power_down_out || sleep_out || mem_test_active_out))
      else $error("start-up test started while barred");
   a_mem_short: assert property (mem_test_active_out |-> mem_cyc_q <= MEMTEST_CYC + 4)
      else $error("memory test too long");
   a_mem_full: assert property ($fell(mem_test_active_out) |-> mem_cyc_q >= MEMTEST_CYC - 4)
      else $error("memory test too short");
   a_ctrl_hold: assert property (!select_low_n_in [*4] |->
      $stable({power_down_out, sleep_out, cont_selftest_out}))
      else $error("control changed inside a frame");
   c_both_tests: cover property (cont_selftest_out && startup_selftest_out);
   c_mem_done: cover property ($fell(mem_test_active_out));
   c_soft_reset: cover property (soft_reset_out);
endmodule
bind acs_spi_slave acs_spi_slave_sva u_acs_spi_slave_sva (.clk_in(clk_in), .rst_in(rst_in),
   .select_low_n_in(select_low_n_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
   .power_down_out(power_down_out), .sleep_out(sleep_out),
   .cont_selftest_out(cont_selftest_out), .mem_test_active_out(mem_test_active_out),
   .startup_selftest_out(startup_selftest_out), .soft_reset_out(soft_reset_out));
`default_nettype wire

// ---- dv/acs_master_model.sv ----
// serial bus master model sending frames to the slave
`timescale 1ns/10ps
`default_nettype none
module acs_master_model (
   // serial link
   output logic sck_out,
   output logic select_low_n_out,
   output logic mosi_out,
   input wire logic miso_in,
   input wire logic miso_oe_in
);
   initial begin
      sck_out = 1'b0;
      select_low_n_out = 1'b0;
      mosi_out = 1'b0;
      // a clean select rise clears the link side before the first frame
      #5;
      select_low_n_out = 1'b1;
   end
   // one frame of n clocks, 80 ns period, clock still outside frames
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r,
         output logic oe);
      r = 16'h0000;
      oe = 1'b0;
      #13;
      mosi_out = w[15];
      select_low_n_out = 1'b0;
      #40;
      for (int i = 0; i < n; i++) begin
         r[15 - i] = miso_oe_in ? miso_in : ~miso_in;
         oe = oe | miso_oe_in;
         sck_out = 1'b1;
         #40;
         sck_out = 1'b0;
         w = w << 1;
         mosi_out = w[15];
         #40;
      end
      select_low_n_out = 1'b1;
      mosi_out = ~mosi_out;
      #500;
   endtask
endmodule
`default_nettype wire

// ---- dv/accel_spi_slave_ctrl_tb.sv ----
// self-checking bench for the serial register slave
`timescale 1ns/10ps
`default_nettype none
module accel_spi_slave_ctrl_tb;
   typedef struct packed {logic [5:0] a; logic w; logic [7:0] d; logic [7:0] e; logic p;
      logic [4:0] c;} acs_row_t;
   logic clk_in = 1'b0, rst_in = 1'b1, uv = 1'b0, st = 1'b0, saturation_flag = 1'b1, oe;
   logic [7:0] nvm = 8'h13;
   logic [15:0] r;
   logic [7:0] keys [6] = '{8'h0c, 8'h0f, 8'h05, 8'h0c, 8'h05, 8'h0f};
   int n_errors = 0, checked = 0, cyc = 0, n_soft = 0;
   wire logic sck, sel_n, mosi, miso, miso_oe, pdn, slp, cst, mem_test_active, sst, srst;
   wire logic [4:0] ctl = {pdn, slp, cst, mem_test_active, sst};
   acs_row_t rows [15] = '{
      '{6'h00, 1'b0, 8'hff, acs_pkg::REVISION_CODE, 1'b1, 5'h00},
      '{6'h27, 1'b0, 8'h00, {acs_pkg::MULTI_AXIS, 7'h13}, 1'b1, 5'h00},
      '{6'h27, 1'b1, 8'h21, {acs_pkg::MULTI_AXIS, 7'h13}, 1'b1, 5'h00},
      '{6'h27, 1'b0, 8'h00, 8'h21, 1'b1, 5'h00},
      '{6'h01, 1'b0, 8'h00, 8'h40, 1'b1, 5'h00},
      '{6'h01, 1'b1, 8'h28, 8'h40, 1'b1, 5'h10},
      '{6'h01, 1'b0, 8'h00, 8'h20, 1'b0, 5'h10},
      '{6'h01, 1'b1, 8'h26, 8'h20, 1'b0, 5'h10},
      '{6'h01, 1'b1, 8'h40, 8'h20, 1'b0, 5'h00},
      '{6'h01, 1'b0, 8'h00, 8'h00, 1'b0, 5'h00},
      '{6'h01, 1'b1, 8'h16, 8'h00, 1'b0, 5'h08},
      '{6'h01, 1'b1, 8'h08, 8'h10, 1'b0, 5'h00},
      '{6'h3e, 1'b0, 8'h00, 8'h00, 1'b0, 5'h00},
      '{6'h01, 1'b1, 8'h0a, 8'h00, 1'b0, 5'h05},
      '{6'h01, 1'b0, 8'h00, 8'h0a, 1'b0, 5'h05}};
   acs_spi_slave u_acs_spi_slave (.clk_in(clk_in), .rst_in(rst_in), .sck_in(sck),
      .select_low_n_in(sel_n), .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
      .nvm_id_in(nvm), .undervolt_in(uv), .st_status_in(st), .sat_status_in(saturation_flag),
      .power_down_out(pdn), .sleep_out(slp), .cont_selftest_out(cst),
      .mem_test_active_out(mem_test_active), .startup_selftest_out(sst), .soft_reset_out(srst));
   acs_master_model u_acs_master_model (.sck_out(sck), .select_low_n_out(sel_n),
      .mosi_out(mosi), .miso_in(miso), .miso_oe_in(miso_oe));
   always #25 clk_in = ~clk_in;
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xf(input logic [5:0] a, input logic w, input logic [7:0] d, input int n = 16,
         input logic bad = 1'b0);
      u_acs_master_model.xfer({a, w, ~^{a, w} ^ bad, d}, n, r, oe);
   endtask
   function automatic logic [15:0] hdr(input logic f, input logic p, input logic [7:0] e);
      return {1'b0, f, p, st, saturation_flag, 2'b01, ~^e, e};
   endfunction
   task automatic wait_ctl(input logic [4:0] e, input int lim);
      for (int i = 0; i < lim && ctl !== e; i++) @(negedge clk_in);
      chk("ctl", 16'(ctl), 16'(e));
   endtask
   always @(negedge clk_in) begin
      cyc++;
      if (srst === 1'b1) n_soft++;
      if (cyc == 12000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (12) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (3) @(negedge clk_in);
      foreach (rows[i]) begin
         xf(rows[i].a, rows[i].w, rows[i].d);
         chk("frame", {1'b0, r[14:0]}, hdr(1'b0, rows[i].p, rows[i].e));
         chk("ctl", 16'(ctl), 16'(rows[i].c));
      end
      wait_ctl(5'h04, 2500);
      xf(6'h01, 1'b1, 8'h00, 12);
      xf(6'h01, 1'b0, 8'h00);
      chk("short", {1'b0, r[14:0]}, hdr(1'b1, 1'b0, 8'h08));
      xf(6'h01, 1'b1, 8'h00, 16, 1'b1);
      xf(6'h01, 1'b0, 8'h00);
      chk("parity", {1'b0, r[14:0]}, hdr(1'b0, 1'b0, 8'h08));
      xf(6'h01, 1'b1, 8'h00);
      xf(6'h01, 1'b1, 8'h0e);
      chk("memtest", 16'(ctl), 16'h0002);
      xf(6'h01, 1'b1, 8'h20);
      wait_ctl(5'h00, acs_pkg::MEMTEST_CYC);
      xf(6'h01, 1'b1, 8'h01);
      chk("drive", 16'(oe), 16'h0001);
      xf(6'h01, 1'b0, 8'h00);
      chk("float", 16'(oe), 16'h0000);
      @(negedge clk_in);
      nvm = 8'h44;
      st = 1'b1;
      saturation_flag = 1'b0;
      foreach (keys[i]) begin
         xf(6'h03, 1'b1, keys[i]);
         if (i == 2) chk("early", 16'(n_soft), 16'h0000);
      end
      chk("soft", 16'(n_soft), 16'h0001);
      xf(6'h27, 1'b0, 8'h00);
      chk("ident", {1'b0, r[14:0]}, hdr(1'b0, 1'b0, {acs_pkg::MULTI_AXIS, 7'h44}));
      @(negedge clk_in);
      uv = 1'b1;
      @(negedge clk_in);
      uv = 1'b0;
      xf(6'h01, 1'b0, 8'h00);
      chk("undervolt", {1'b0, r[14:0]}, hdr(1'b0, 1'b1, 8'h40));
      @(negedge clk_in);
      rst_in = 1'b1;
      repeat (3) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (3) @(negedge clk_in);
      xf(6'h01, 1'b0, 8'h00);
      chk("reset", {1'b0, r[14:0]}, hdr(1'b0, 1'b1, 8'h40));
      tally_and_finish();
   end
endmodule
`default_nettype wire
